// ---- bench/cer_checker.sv ----
// Checker of bus timing, register reads and user port miss data at the block pins
`timescale 1ns/1ps
module cer_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [cer_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [cer_pkg::BYTE_W-1:0] rd_data_o,
   input wire logic rd_hit_o
);
   import cer_pkg::*;
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire rd = req && !wb_we_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_next: assert property (req |=> wb_ack_o)
      else $error("ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_cause: assert property (wb_ack_o |-> $past(req))
      else $error("ack without request");
   a_dat_holds: assert property (!req |=> $stable(wb_dat_o))
      else $error("read data moved");
   a_miss_zero: assert property (!rd_hit_o |-> rd_data_o == 8'h00)
      else $error("bank miss data");
   a_ctrl_rsvd: assert property (rd && wb_adr_i == OFS_CTRL
      |=> (wb_dat_o & ~CTRL_WMASK) == 32'h0) else $error("ctrl bits");
   a_stat_word: assert property (rd && wb_adr_i == OFS_STAT
      |=> wb_dat_o[7:0] == $past(rd_data_o) && wb_dat_o[31:24] == 8'h00)
      else $error("status word");
   a_unmapped_zero: assert property (rd && wb_adr_i[7:4] != 4'h0
      |=> wb_dat_o == 32'h0) else $error("unmapped read");
   a_iptr_width: assert property (rd && wb_adr_i == OFS_IPTR
      |=> wb_dat_o[31:8] == 24'h0) else $error("pointer width");
endmodule

// ---- bench/cer_user_model.sv ----
// User logic model driving the block user port
`timescale 1ns/1ps
module cer_user_model (
   input wire logic clk_i,
   input wire logic req_we_i,
   input wire logic [cer_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic [cer_pkg::BANK_W-1:0] req_bank_i,
   input wire logic [cer_pkg::BYTE_W-1:0] req_data_i,
   output logic [cer_pkg::ADDR_W-1:0] addr_o,
   output logic [cer_pkg::BANK_W-1:0] bank_o,
   output logic [cer_pkg::BYTE_W-1:0] data_o,
   output logic we_o
);
   import cer_pkg::*;
   always @(posedge clk_i) begin
      we_o <= req_we_i;
      addr_o <= req_addr_i;
      bank_o <= req_bank_i;
      // Data invalid when idle
      data_o <= req_we_i ? req_data_i : ~req_data_i;
   end
endmodule

// ---- bench/configurable_embedded_ram_tb_top.sv ----
// Testbench of the embedded RAM block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
$display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module configurable_embedded_ram_tb_top;
   import cer_pkg::*;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, we_i;
   logic rd_hit_o, req_we;
   logic [7:0] wb_adr_i, wr_data_i, rd_data_o, req_data;
   logic [3:0] wb_sel_i, bank_i, req_bank;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [10:0] addr_i, req_addr;
   int err_count, checks;
   logic glob_en, glob_we;
   logic [1:0] ded_clk;
   assign glob_we = we_i & glob_en;
   cer_top cer_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .addr_i,
      .bank_i, .wr_data_i, .we_i, .glob_we_i(glob_we), .ded_clk_i(ded_clk),
      .rd_data_o, .rd_hit_o);
   cer_user_model cer_user_model_inst (.clk_i, .req_we_i(req_we),
      .req_addr_i(req_addr), .req_bank_i(req_bank), .req_data_i(req_data),
      .addr_o(addr_i), .bank_o(bank_i), .data_o(wr_data_i), .we_o(we_i));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task automatic user(input logic w, input logic [10:0] a,
      input logic [3:0] b, input logic [7:0] d);
      @(posedge clk_i);
      req_we <= w;
      req_addr <= a;
      req_bank <= b;
      req_data <= d;
      @(posedge clk_i);
      req_we <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   task automatic t_regs;
      rchk(OFS_CTRL, CTRL_RST);
      wb(1'b1, OFS_CTRL, 32'hffff_ffff);
      rchk(OFS_CTRL, CTRL_WMASK);
      wb(1'b1, OFS_CTRL, 32'h0);
      wb(1'b1, 8'h10, 32'hffff_ffff);
      rchk(8'h10, 32'h0);
   endtask
   task automatic t_load;
      wb(1'b1, OFS_IPTR, 32'h0);
      wb(1'b1, OFS_IDAT, 32'h0000_00a5);
      wb(1'b1, OFS_IDAT, 32'hffff_ff00);
      rchk(OFS_IPTR, 32'h2);
      wb(1'b1, OFS_IPTR, 32'h1);
      rchk(OFS_IDAT, 32'h0);
   endtask
   task automatic t_shapes;
      int w;
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, OFS_CTRL, k << 1);
         w = 8 >> k;
         for (int s = 0; s < (1 << k); s++) begin
            user(1'b0, 11'(s), 4'h0, 8'h00);
            `CHK(rd_data_o, 8'((8'ha5 >> (s * w)) & ((1 << w) - 1)))
         end
      end
   endtask
   task automatic t_write;
      wb(1'b1, OFS_CTRL, 32'h6);
      user(1'b1, 11'h00d, 4'h0, 8'h01);
      `CHK(rd_data_o, 8'h01)
      rchk(OFS_IDAT, 32'h20);
      rchk(OFS_STAT, 32'h0000_0101);
   endtask
   task automatic t_rom;
      wb(1'b1, OFS_CTRL, 32'h7);
      user(1'b1, 11'h008, 4'h0, 8'h01);
      rchk(OFS_IDAT, 32'h20);
      user(1'b0, 11'h00d, 4'h0, 8'h00);
      rchk(OFS_STAT, 32'h0000_0101);
   endtask
   task automatic t_bank;
      wb(1'b1, OFS_CTRL, 32'h0001_3000);
      user(1'b0, 11'h001, 4'h2, 8'h00);
      `CHK({rd_hit_o, rd_data_o}, 9'h000)
      user(1'b0, 11'h001, 4'h3, 8'h00);
      `CHK({rd_hit_o, rd_data_o}, 9'h120)
   endtask
   task automatic t_qreg;
      wb(1'b1, OFS_CTRL, 32'h20);
      user(1'b0, 11'h000, 4'h0, 8'h00);
      req_addr <= 11'h001;
      @(posedge clk_i);
      #1;
      `CHK(rd_data_o, 8'ha5)
      @(posedge clk_i);
      #1;
      `CHK(rd_data_o, 8'h20)
   endtask
   task automatic t_glob;
      wb(1'b1, OFS_IPTR, 32'h2);
      wb(1'b1, OFS_IDAT, 32'h0000_003c);
      wb(1'b1, OFS_CTRL, 32'h100);
      user(1'b1, 11'h002, 4'h0, 8'h5a);
      `CHK(rd_data_o, 8'h3c)
      @(posedge clk_i);
      glob_en <= 1'b1;
      user(1'b1, 11'h002, 4'h0, 8'h5a);
      `CHK(rd_data_o, 8'h5a)
   endtask
   task automatic t_clocks;
      wb(1'b1, OFS_IDAT, 32'h0000_0011);
      wb(1'b1, OFS_CTRL, 32'h58);
      @(posedge clk_i);
      req_we <= 1'b1;
      req_addr <= 11'h003;
      req_data <= 8'h77;
      ded_clk <= 2'h1;
      repeat (3) @(posedge clk_i);
      #1;
      `CHK(rd_data_o, 8'h5a)
      repeat (3) @(posedge clk_i);
      req_we <= 1'b0;
      ded_clk <= 2'h0;
      repeat (6) @(posedge clk_i);
      #1;
      `CHK(rd_data_o, 8'h11)
      @(posedge clk_i);
      ded_clk <= 2'h1;
      repeat (6) @(posedge clk_i);
      ded_clk <= 2'h0;
      repeat (6) @(posedge clk_i);
      #1;
      `CHK(rd_data_o, 8'h77)
      wb(1'b1, OFS_CTRL, 32'ha0);
      user(1'b0, 11'h000, 4'h0, 8'h00);
      `CHK(rd_data_o, 8'h77)
      @(posedge clk_i);
      ded_clk <= 2'h2;
      repeat (6) @(posedge clk_i);
      ded_clk <= 2'h0;
      repeat (2) @(posedge clk_i);
      #1;
      `CHK(rd_data_o, 8'ha5)
   endtask
   task automatic results;
      if (err_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, req_we} = 4'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      req_addr = 11'h000;
      req_bank = 4'h0;
      req_data = 8'h00;
      glob_en = 1'b0;
      ded_clk = 2'h0;
      err_count = 0;
      checks = 0;
      rst_i = 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_load();
      t_shapes();
      t_write();
      t_rom();
      t_bank();
      t_qreg();
      t_glob();
      t_clocks();
      results();
   end
   initial begin
      #400000;
      err_count++;
      results();
   end
endmodule
bind cer_top cer_checker cer_checker_inst (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .rd_data_o,
   .rd_hit_o);

// ---- inc/cer_pkg.sv ----
// Constants and types shared by the embedded RAM block files
package cer_pkg;
   // ******************************
   // Storage geometry
   // ******************************
   localparam int unsigned MEM_BITS = 2048;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned ROWS = MEM_BITS / BYTE_W;
   localparam int unsigned ROW_W = 8;
   localparam int unsigned ADDR_W = 11;
   localparam int unsigned BANK_W = 4;
   localparam int unsigned NUM_DCLK = 2;
   localparam int unsigned WB_ADR_W = 8;

   // ******************************
   // Register offsets (byte addresses)
   // ******************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_IPTR = 8'h08;
   localparam logic [7:0] OFS_IDAT = 8'h0c;

   // ******************************
   // Control register fields
   // ******************************
   localparam int unsigned CTRL_ROM = 0;
   localparam int unsigned CTRL_SHAPE = 1;
   localparam int unsigned CTRL_DREG = 3;
   localparam int unsigned CTRL_AREG = 4;
   localparam int unsigned CTRL_QREG = 5;
   localparam int unsigned CTRL_ICLK = 6;
   localparam int unsigned CTRL_OCLK = 7;
   localparam int unsigned CTRL_WESRC = 8;
   localparam int unsigned CTRL_BANK = 12;
   localparam int unsigned CTRL_CASC = 16;
   localparam logic [31:0] CTRL_WMASK = 32'h0001_f1ff;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;

   // ******************************
   // Status register fields
   // ******************************
   localparam int unsigned STAT_Q = 0;
   localparam int unsigned STAT_WCNT = 8;
   localparam int unsigned WCNT_W = 16;

   // Port shapes, index k gives 8>>k bits per word
   typedef enum logic [1:0] {
      CER_SHAPE_256X8,
      CER_SHAPE_512X4,
      CER_SHAPE_1024X2,
      CER_SHAPE_2048X1
   } cer_shape_t;
endpackage

// ---- inc/cer_stage_if.sv ----
// Interface between the block and one optional pipeline stage
`timescale 1ns/1ps
interface cer_stage_if #(parameter int W = 8);
   logic [W-1:0] d;
   logic [W-1:0] q;
   logic tick;
   logic bypass;
   modport stage(input d, input tick, input bypass, output q);
   modport user(output d, output tick, output bypass, input q);
endinterface

// ---- logic/cer_stage.sv ----
// Optional pipeline register with bypass
`timescale 1ns/1ps
module cer_stage (
   input wire logic clk_i,
   input wire logic rst_i,
   cer_stage_if.stage st
);
   logic [$bits(st.d)-1:0] q_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_ff <= '0;
      end else if (st.tick) begin
         q_ff <= st.d;
      end
   end

   assign st.q = st.bypass ? st.d : q_ff;
endmodule

// ---- logic/cer_top.sv ----
// Configurable 2048-bit embedded RAM block with Wishbone control port
`timescale 1ns/1ps
// Contract
// (RULE1) Block holds 2048 bits usable as RAM, ROM, dual-port or FIFO store.
// (RULE2) RAM port shape selectable: 256x8, 512x4, 1024x2 or 2048x1.
// (RULE3) Write strobe made inside from the clock; user meets setup/hold only.
// (RULE4) Input side and output side may run from two different clocks.
// (RULE5) Data, address/write-enable and output registers each optional.
// (RULE6) ROM mode keeps loaded contents, ignores writes, reads as lookup.
// (RULE7) Blocks share address and control side by side for wider words.
// (RULE8) Blocks cascade in depth by bank select without added delay.
// (RULE9) Write enable from global line or local logic; clocks from pins.
// (RULE10) 8 to 11 address bits; extra low bits pick slice in byte.
module cer_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [cer_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [cer_pkg::ADDR_W-1:0] addr_i,
   input wire logic [cer_pkg::BANK_W-1:0] bank_i,
   input wire logic [cer_pkg::BYTE_W-1:0] wr_data_i,
   input wire logic we_i,
   input wire logic glob_we_i,
   input wire logic [cer_pkg::NUM_DCLK-1:0] ded_clk_i,
   output logic [cer_pkg::BYTE_W-1:0] rd_data_o,
   output logic rd_hit_o
);
   import cer_pkg::*;

   localparam int unsigned AW = 1 + ADDR_W + BANK_W;
   localparam int unsigned QW = 1 + BYTE_W;

   // ******************************
   // Configuration and state
   // ******************************
   logic [31:0] ctrl_ff;
   logic [31:0] nxt_ctrl;
   logic [ROW_W-1:0] iptr_ff;
   logic [WCNT_W-1:0] wcnt_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic [BYTE_W-1:0] mem_ff [ROWS];

   wire rom_mode = ctrl_ff[CTRL_ROM];
   wire [1:0] shape = ctrl_ff[CTRL_SHAPE+:2];
   wire [BANK_W-1:0] bank_id = ctrl_ff[CTRL_BANK+:BANK_W];

   // ******************************
   // Dedicated clock pin synchronisers
   // ******************************
   logic [NUM_DCLK-1:0] sync1_ff;
   logic [NUM_DCLK-1:0] sync2_ff;
   logic [NUM_DCLK-1:0] sync3_ff;
   logic [NUM_DCLK-1:0] lvl_ff;

   wire [NUM_DCLK-1:0] agree = ~(sync2_ff ^ sync3_ff);
   wire [NUM_DCLK-1:0] dclk_rise = agree & sync2_ff & ~lvl_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
         lvl_ff <= '0;
      end else begin
         sync1_ff <= ded_clk_i;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         lvl_ff <= (agree & sync2_ff) | (~agree & lvl_ff);
      end
   end

   // (RULE4) Separate input and output clocks
   wire in_tick = ctrl_ff[CTRL_ICLK] ? dclk_rise[0] : 1'b1;
   wire out_tick = ctrl_ff[CTRL_OCLK] ? dclk_rise[1] : 1'b1;

   // ******************************
   // Optional pipeline stages
   // ******************************
   cer_stage_if #(.W(BYTE_W)) din_if();
   cer_stage_if #(.W(AW)) adr_if();
   cer_stage_if #(.W(QW)) out_if();

   // (RULE9) Write enable source select
   wire we_src = ctrl_ff[CTRL_WESRC] ? glob_we_i : we_i;

   // (RULE5) Independent register bypass per stage
   assign din_if.d = wr_data_i;
   assign din_if.tick = in_tick;
   assign din_if.bypass = ~ctrl_ff[CTRL_DREG];
   assign adr_if.d = {we_src, addr_i, bank_i};
   assign adr_if.tick = in_tick;
   assign adr_if.bypass = ~ctrl_ff[CTRL_AREG];
   assign out_if.tick = out_tick;
   assign out_if.bypass = ~ctrl_ff[CTRL_QREG];

   cer_stage u_din (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .st(din_if.stage)
   );
   cer_stage u_adr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .st(adr_if.stage)
   );
   cer_stage u_out (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .st(out_if.stage)
   );

   wire [BYTE_W-1:0] s_din = din_if.q;
   wire s_we = adr_if.q[AW-1];
   wire [ADDR_W-1:0] s_addr = adr_if.q[BANK_W+:ADDR_W];
   wire [BANK_W-1:0] s_bank = adr_if.q[BANK_W-1:0];

   // ******************************
   // Shape decode and slice select
   // ******************************
   function automatic logic [7:0] fn_mask(input logic [1:0] k);
      case (k)
         CER_SHAPE_256X8: fn_mask = 8'hff;
         CER_SHAPE_512X4: fn_mask = 8'h0f;
         CER_SHAPE_1024X2: fn_mask = 8'h03;
         default: fn_mask = 8'h01;
      endcase
   endfunction

   function automatic logic [2:0] fn_off(input logic [1:0] k,
                                         input logic [2:0] a);
      case (k)
         CER_SHAPE_256X8: fn_off = 3'h0;
         CER_SHAPE_512X4: fn_off = {a[0], 2'h0};
         CER_SHAPE_1024X2: fn_off = {a[1:0], 1'h0};
         default: fn_off = a;
      endcase
   endfunction

   // (RULE2) Port shape picks word width
   wire [7:0] slice_mask = fn_mask(shape);
   // (RULE10) Upper bits pick row, low bits the slice
   wire [ADDR_W-1:0] addr_sh = s_addr >> shape;
   wire [ROW_W-1:0] row = addr_sh[ROW_W-1:0];
   wire [2:0] off = fn_off(shape, s_addr[2:0]);
   wire [7:0] place_mask = slice_mask << off;
   wire [7:0] place_din = (s_din & slice_mask) << off;

   // (RULE8) Bank match for depth cascade
   wire hit = ctrl_ff[CTRL_CASC] ? (s_bank == bank_id) : 1'b1;

   // (RULE1) One 2048-bit array for all uses
   wire [7:0] row_data = mem_ff[row];
   wire [7:0] row_shift = row_data >> off;
   wire [7:0] raw_q = row_shift & slice_mask;
   wire [7:0] new_row = (row_data & ~place_mask) | place_din;

   // (RULE3) Internal write strobe on the clock
   // (RULE6) Writes ignored in ROM mode
   wire user_we = s_we & in_tick & hit & ~rom_mode;

   // (RULE6) Lookup result, combinational when output stage bypassed
   // (RULE7) Shared address, unselected block outputs zero
   assign out_if.d = {hit, hit ? raw_q : 8'h00};
   assign rd_data_o = out_if.q[BYTE_W-1:0];
   assign rd_hit_o = out_if.q[QW-1];

   // ******************************
   // Wishbone slave
   // ******************************
   wire req = wb_cyc_i & wb_stb_i;
   wire fire = req & ack_ff;
   wire mapped = (wb_adr_i[7:4] == 4'h0) & (wb_adr_i[1:0] == 2'h0);
   wire sel_ctrl = mapped & (wb_adr_i == OFS_CTRL);
   wire sel_stat = mapped & (wb_adr_i == OFS_STAT);
   wire sel_iptr = mapped & (wb_adr_i == OFS_IPTR);
   wire sel_idat = mapped & (wb_adr_i == OFS_IDAT);
   wire wr_fire = fire & wb_we_i;
   wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] ctrl_bm = lane_mask & CTRL_WMASK;
   wire init_we = wr_fire & sel_idat & wb_sel_i[0];
   wire [31:0] stat_word = {8'h00, wcnt_ff, rd_data_o};
   wire [31:0] rd_mux = sel_ctrl ? ctrl_ff :
                        sel_stat ? stat_word :
                        sel_iptr ? {24'h0, iptr_ff} :
                        sel_idat ? {24'h0, mem_ff[iptr_ff]} : 32'h0;

   assign nxt_ctrl = (ctrl_ff & ~ctrl_bm) | (wb_dat_i & ctrl_bm);
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0;
      end else begin
         ack_ff <= req & ~ack_ff;
         if (req & ~ack_ff) begin
            dat_ff <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= CTRL_RST;
         iptr_ff <= '0;
         wcnt_ff <= '0;
      end else begin
         if (wr_fire & sel_ctrl) begin
            ctrl_ff <= nxt_ctrl;
         end
         if (wr_fire & sel_iptr & wb_sel_i[0]) begin
            iptr_ff <= wb_dat_i[ROW_W-1:0];
         end else if (init_we) begin
            iptr_ff <= iptr_ff + 8'h01;
         end
         if (user_we) begin
            wcnt_ff <= wcnt_ff + 16'h0001;
         end
      end
   end

   // (RULE6) Contents loaded through init port before use
   always_ff @(posedge clk_i) begin
      if (init_we) begin
         mem_ff[iptr_ff] <= wb_dat_i[BYTE_W-1:0];
      end else if (user_we) begin
         mem_ff[row] <= new_row;
      end
   end
endmodule
